// ===== bsm_defs.svh
// Constants for the bit-set, shift and move execute datapath.
`ifndef BSM_DEFS_SVH
`define BSM_DEFS_SVH
`define BSM_ADDR_W      7
`define BSM_DATA_W      8
`define BSM_BIT_W       3
`define BSM_MSB         7
`define BSM_DEST_WREG   1'b0
`define BSM_DEST_FILE   1'b1
`define BSM_W_RESET     8'h00
`define BSM_FLAG_RESET  1'b0
`define BSM_ADDR_RESET  7'h00
`define BSM_DATA_RESET  8'h00
`define BSM_PULSE_RESET 1'b0
`endif

// ===== bsm_pkg.sv
// Types shared by the execute datapath.
package bsm_pkg;
	typedef enum logic [3:0]
	{
		BSM_OP_SET_ONE_POSITION = 4'b0001,
		BSM_OP_SHIFT_TOWARD_MSB = 4'b0010,
		BSM_OP_SHIFT_TOWARD_LSB = 4'b0100,
		BSM_OP_COPY_OPERAND     = 4'b1000
	} bsm_op_t;
endpackage

// ===== bsm_execute.sv
// Single-cycle execute datapath for set, shift and copy instructions.
`include "bsm_defs.svh"
module bsm_execute
	import bsm_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	input  wire logic                     clk_en,
	input  wire logic                     op_valid,
	input  wire logic [3:0]               op_code,
	input  wire logic [`BSM_ADDR_W-1:0]   op_addr,
	input  wire logic [`BSM_BIT_W-1:0]    op_bit,
	input  wire logic                     op_dest_given,
	input  wire logic                     op_dest,
	input  wire logic [`BSM_DATA_W-1:0]   file_rdata,
	output logic      [`BSM_ADDR_W-1:0]   file_raddr,
	output logic                          file_we,
	output logic      [`BSM_ADDR_W-1:0]   file_waddr,
	output logic      [`BSM_DATA_W-1:0]   file_wdata,
	output logic      [`BSM_DATA_W-1:0]   wreg,
	output logic                          flag_zero,
	output logic                          flag_carry,
	output logic                          op_done
);
	// The file memory answers its read address in the same cycle, so each
	// instruction reads and modifies within one clock; the registered write strobe updates the file at the following edge.

	// Forces one bit position high and keeps the other seven bits.
	function automatic logic [7:0] set_bit_of(
		input logic [7:0] v,
		input logic [2:0] pos
	);
		logic [7:0] mask;
		mask       = 8'h01 << pos;
		set_bit_of = v | mask;
	endfunction

	function automatic logic [7:0] shift_up_of(
		input logic [7:0] v
	);
		shift_up_of = {v[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] shift_down_of(
		input logic [7:0] v
	);
		shift_down_of = {1'b0, v[`BSM_MSB:1]};
	endfunction

	function automatic logic carry_up_of(
		input logic [7:0] v
	);
		carry_up_of = v[`BSM_MSB];
	endfunction

	function automatic logic carry_down_of(
		input logic [7:0] v
	);
		carry_down_of = v[0];
	endfunction

	function automatic logic is_zero(
		input logic [7:0] v
	);
		is_zero = (v == 8'h00);
	endfunction

	// An instruction without a selector writes back to the file register.
	function automatic logic dest_of(
		input logic given,
		input logic sel
	);
		dest_of = given ? sel : `BSM_DEST_FILE;
	endfunction

	wire bsm_op_t          op          = bsm_op_t'(op_code);
	wire logic             go          = op_valid & clk_en;
	wire logic             is_set      = (op == BSM_OP_SET_ONE_POSITION);
	wire logic             is_lsl      = (op == BSM_OP_SHIFT_TOWARD_MSB);
	wire logic             is_lsr      = (op == BSM_OP_SHIFT_TOWARD_LSB);
	wire logic             is_mov      = (op == BSM_OP_COPY_OPERAND);
	wire logic             known       = is_set | is_lsl | is_lsr | is_mov;
	wire logic             take        = op_valid & known;
	wire logic             is_shift    = is_lsl | is_lsr;
	wire logic             dest        = dest_of(op_dest_given, op_dest);

	wire logic [7:0]       set_res     = set_bit_of(file_rdata, op_bit);
	wire logic [7:0]       lsl_res     = shift_up_of(file_rdata);
	wire logic [7:0]       lsr_res     = shift_down_of(file_rdata);
	wire logic             lsl_carry   = carry_up_of(file_rdata);
	wire logic             lsr_carry   = carry_down_of(file_rdata);

	logic      [7:0]       result;
	logic                  to_file;
	logic                  to_wreg;
	logic                  zero_load;
	logic                  carry_load;
	logic                  next_we;
	logic      [6:0]       next_waddr;
	logic      [7:0]       next_wdata;
	logic                  next_done;
	logic                  next_zero;
	logic                  next_carry;

	// Copy passes the operand through unchanged, as do unknown codes.
	assign result     = is_set ? set_res :
	                    is_lsl ? lsl_res :
	                    is_lsr ? lsr_res :
	                    file_rdata;

	// Set always writes back to the file; the others follow the selector.
	assign to_file    = is_set | (dest == `BSM_DEST_FILE);
	assign to_wreg    = go & known & ~is_set & (dest == `BSM_DEST_WREG);
	assign file_raddr = op_addr;

	// Set leaves both flags alone; copy touches only the zero flag.
	assign zero_load  = go & (is_shift | is_mov);
	assign carry_load = go & is_shift;

	assign next_we    = take & to_file;
	assign next_waddr = op_addr;
	assign next_wdata = result;
	assign next_done  = take;
	assign next_zero  = is_zero(result);
	assign next_carry = is_lsl ? lsl_carry : lsr_carry;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			file_we <= `BSM_PULSE_RESET;
		end
		else if (clk_en)
		begin
			file_we <= next_we;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			file_waddr <= `BSM_ADDR_RESET;
		end
		else if (clk_en)
		begin
			file_waddr <= next_waddr;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			file_wdata <= `BSM_DATA_RESET;
		end
		else if (clk_en)
		begin
			file_wdata <= next_wdata;
		end
	end

	// The done pulse drops again at the next enabled edge without a request.
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			op_done <= `BSM_PULSE_RESET;
		end
		else if (clk_en)
		begin
			op_done <= next_done;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wreg <= `BSM_W_RESET;
		end
		else if (to_wreg)
		begin
			wreg <= result;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flag_zero <= `BSM_FLAG_RESET;
		end
		else if (zero_load)
		begin
			flag_zero <= next_zero;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flag_carry <= `BSM_FLAG_RESET;
		end
		else if (carry_load)
		begin
			flag_carry <= next_carry;
		end
	end
endmodule

// ===== bsm_mem_model.sv
// Data memory model with combinational read and write on the strobe.
module bsm_mem_model (
	input wire logic sys_clk, we,
	input wire logic [6:0] waddr, raddr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] m [128];
	initial
	begin
		for (int i = 0; i < 128; i++)
			m[i] = 8'(i) ^ 8'h5a;
	end
	assign rdata = m[raddr];
	always @(posedge sys_clk)
		if (we)
			m[waddr] <= wdata;
endmodule

// ===== bsm_execute_chk.sv
// Port assertions for the execute datapath.
module bsm_execute_chk (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       clk_en,
	input wire logic       op_valid,
	input wire logic [3:0] op_code,
	input wire logic [6:0] op_addr,
	input wire logic [2:0] op_bit,
	input wire logic       op_dest_given,
	input wire logic       op_dest,
	input wire logic [7:0] file_rdata,
	input wire logic       file_we,
	input wire logic [6:0] file_waddr,
	input wire logic [7:0] file_wdata,
	input wire logic [7:0] wreg,
	input wire logic       flag_zero,
	input wire logic       flag_carry,
	input wire logic       op_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// High when the result goes back to the file register.
	wire logic df = !op_dest_given | op_dest;
	sequence taken(logic [3:0] c);
		clk_en && op_valid && op_code == c;
	endsequence
	sequence nothing_taken;
		clk_en && !(op_valid && $onehot(op_code));
	endsequence
	AST_SET: assert property (taken(4'h1) |=> file_we && $stable(flag_zero)
		&& $stable(flag_carry) && file_wdata == ($past(file_rdata) | 8'h01 << $past(op_bit)))
		else $error("set bit wrong");
	AST_LSL: assert property (taken(4'h2) ##0 df |=> file_we
		&& file_wdata == {$past(file_rdata[6:0]), 1'b0}
		&& flag_carry == $past(file_rdata[7]) && flag_zero == !file_wdata) else $error("left shift wrong");
	AST_LSR: assert property (taken(4'h4) ##0 !df |=> !file_we
		&& wreg == {1'b0, $past(file_rdata[7:1])}
		&& flag_carry == $past(file_rdata[0]) && flag_zero == !wreg) else $error("right shift wrong");
	AST_COPY: assert property (taken(4'h8) ##0 !df |=> op_done && !file_we && wreg == $past(file_rdata)
		&& $stable(flag_carry) && flag_zero == !wreg) else $error("copy wrong");
	AST_DFLT: assert property (taken(4'h8) ##0 !op_dest_given |=> file_we && file_waddr == $past(op_addr))
		else $error("default destination wrong");
	AST_REFUSE: assert property (nothing_taken |=> !op_done && !file_we && $stable(wreg)
		&& $stable(flag_zero) && $stable(flag_carry)) else $error("refused request changed state");
	AST_FREEZE: assert property (!clk_en |=> $stable(op_done) && $stable(file_we) && $stable(file_wdata)
		&& $stable(wreg) && $stable(flag_zero) && $stable(flag_carry)) else $error("state moved while frozen");
endmodule
bind bsm_execute bsm_execute_chk i_chk (.*);

// ===== bit_shift_move_execute_tb_top.sv
// Random self-checking bench for the set, shift and copy datapath.
module bit_shift_move_execute_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, nrst = 0, clk_en = 0, op_valid = 0, op_dest_given = 0, op_dest = 0;
	logic file_we, flag_zero, flag_carry, op_done, ez = 0, ec = 0, ewe = 0, edn = 0;
	logic [3:0] op_code = 0;
	logic [6:0] op_addr = 0, file_raddr, file_waddr;
	logic [2:0] op_bit = 0;
	logic [7:0] file_rdata, file_wdata, wreg, v, ew = 0;
	logic [31:0] x = 21188;
	int n_fail = 0, checked = 0;
	always #5 sys_clk = ~sys_clk;
	bsm_execute i_dut (.*);
	bsm_mem_model i_mem (.sys_clk, .we(file_we), .waddr(file_waddr), .wdata(file_wdata),
		.raddr(file_raddr), .rdata(file_rdata));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] exp_res(input logic [3:0] c, input logic [7:0] r,
		input logic [2:0] b);
		if (c[0])
			return r | (8'h01 << b);
		if (c[1])
			return {r[6:0], 1'b0};
		if (c[2])
			return {1'b0, r[7:1]};
		return r;
	endfunction
	task automatic chk(input logic [7:0] e, input logic [7:0] a);
		checked++;
		if (a !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, a, e);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#50000;
		n_fail++;
		end_of_test();
	end
	initial
	begin
		repeat (10) @(negedge sys_clk);
		nrst = 1;
		for (int i = 0; i < 400; i++)
		begin
			if (i == 200)
			begin
				nrst = 0;
				@(negedge sys_clk);
				chk(8'h00, {4'h0, file_we, op_done, flag_zero, flag_carry});
				chk(8'h00, wreg);
				chk(8'h00, file_wdata);
				nrst = 1;
				{ewe, edn, ez, ec} = 4'h0;
				ew = 8'h00;
				$display("reset test done");
			end
			x = xs(x);
			// Address 5a holds zero so the zero flag is exercised early.
			{clk_en, op_bit, op_dest_given, op_dest} = {x[9:7] != 0, x[4:2], x[6:5]};
			op_valid = i < 4 || x[11:10] != 0;
			op_code = x[13:12] == 0 ? 4'h3 : 4'h1 << x[1:0];
			op_addr = i < 4 ? 7'h5a : x[20:14];
			#1;
			v = exp_res(op_code, file_rdata, op_bit);
			if (clk_en)
			begin
				edn = op_valid & (op_code != 4'h3);
				ewe = edn & (op_code[0] | !op_dest_given | op_dest);
				if (edn & ~op_code[0]) ez = v == 0;
				if (edn & op_code[1]) ec = file_rdata[7];
				if (edn & op_code[2]) ec = file_rdata[0];
				if (edn & ~ewe) ew = v;
			end
			@(negedge sys_clk);
			chk({4'h0, ewe, edn, ez, ec}, {4'h0, file_we, op_done, flag_zero, flag_carry});
			chk(ew, wreg);
			if (clk_en & ewe) chk(v, file_wdata);
		end
		$display("random test done");
		end_of_test();
	end
endmodule
